// ===== ccd_pkg.sv
/*
 * shared constants and types for the configuration clock and data pin block.
 * assumes a 100 MHz system clock and an 80 ns configuration clock period.
 */
`default_nettype none

package ccd_pkg;

	// configuration schemes chosen by the mode straps
	typedef enum logic [1:0] {
		passive_serial_scheme,
		fast_passive_parallel_scheme,
		active_serial_scheme,
		active_parallel_scheme
	} ccd_scheme_t;

	// block sequence
	typedef enum logic [1:0] {
		st_idle,
		st_config,
		st_user
	} ccd_state_t;

	// timing
	localparam int unsigned SYS_CLK_MHZ       = 100;
	localparam int unsigned CFG_CLK_PERIOD_NS = 80;
	localparam int unsigned CFG_CLK_HALF_CYC  = (CFG_CLK_PERIOD_NS * SYS_CLK_MHZ) / 2000;
	localparam int unsigned DIV_W             = 3;
	localparam logic [DIV_W-1:0] DIV_LAST     = DIV_W'(CFG_CLK_HALF_CYC - 1);

	// pin widths and idle levels
	localparam int unsigned DATA_W            = 16;
	localparam int unsigned BYTE_W            = 8;
	localparam logic        CLK_IDLE_LEVEL    = 1'b1;

	// serial memory read command, shifted out msb first
	localparam int unsigned CMD_W             = 32;
	localparam logic [CMD_W-1:0] AS_READ_CMD  = 32'h0300_0000;
	localparam logic [5:0]  CMD_BITS          = 6'h20;
	localparam logic [2:0]  BIT_LAST          = 3'h7;

endpackage : ccd_pkg

`default_nettype wire

// ===== ccd_sync_if.sv
/*
 * carries the synchronised link clock edge and data lines between modules.
 * assumes both ends run on the system clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface ccd_sync_if;
	logic        clk_rise;	// one-cycle pulse per link clock rising edge
	logic [15:0] data;	// filtered data line levels

	modport src (output clk_rise, data);
	modport dst (input  clk_rise, data);
endinterface : ccd_sync_if

`default_nettype wire

// ===== ccd_pin_sync.sv
/*
 * three-stage synchronisers and glitch filter for the link clock and data pins.
 * assumes the pins are asynchronous to mclk_i and change slower than mclk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module ccd_pin_sync (
	// clock and reset
	input  wire logic                      mclk_i,
	input  wire logic                      rst_n_i,
	// pins
	input  wire logic                      config_clock_i,
	input  wire logic [ccd_pkg::DATA_W-1:0] data_i,
	// synchronised view
	ccd_sync_if.src                        sync
);
	import ccd_pkg::*;

	localparam int unsigned N = DATA_W + 1;
	// clock stage starts at its idle level so a high idle clock gives no false rise
	localparam logic [N-1:0] RST_LVL = {{DATA_W{1'b0}}, CLK_IDLE_LEVEL};

	logic [N-1:0] pin_in;
	logic [N-1:0] s1;
	logic [N-1:0] s2;
	logic [N-1:0] s3;
	logic [N-1:0] filt;
	logic         rise_q;

	assign pin_in = {data_i, config_clock_i};

	// per pin: three flops, level accepted once stages two and three agree
	for (genvar i = 0; i < N; i++) begin : g_pin
		always_ff @(posedge mclk_i) begin
			if (!rst_n_i) begin
				s1[i]   <= RST_LVL[i];
				s2[i]   <= RST_LVL[i];
				s3[i]   <= RST_LVL[i];
				filt[i] <= RST_LVL[i];
			end else begin
				s1[i] <= pin_in[i];
				s2[i] <= s1[i];
				s3[i] <= s2[i];
				if (s2[i] == s3[i]) begin
					filt[i] <= s3[i];
				end
			end
		end
	end

	// rising edge of the filtered link clock
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			rise_q <= 1'b0;
		end else begin
			rise_q <= (s2[0] == s3[0]) && s3[0] && !filt[0];
		end
	end

	assign sync.clk_rise = rise_q;
	assign sync.data     = filt[N-1:1];

endmodule : ccd_pin_sync

`default_nettype wire

// ===== ccd_cfg_pins.sv
/*
 * configuration clock and lowest data pins of the configuration port: captures
 * the configuration stream in all four schemes and hands the data pins, and in
 * active schemes the clock pin, to user logic afterwards.
 * assumes the loader core raises cfg_complete_i when the image is in, and
 * that scheme_i and ap_word_i are steady straps around reset release.
 */
// Functional notes
// - active serial: device drives config clock
// - active parallel: device drives config clock
// - active schemes: clock idles after configuration
// - only active schemes give clock to user
// - configured device ignores config clock toggling
// - serial schemes carry bits on line zero
// - after active serial, line zero input
// - after passive schemes, line zero user pin
// - after active parallel, line zero bidirectional
// - active serial: line one sends commands
// - after active serial, line one output
// - passive serial: line one tristated
// - after fast parallel, line one user pin
// - active parallel: flash gives byte or word
// - after active parallel, line one bidirectional
// - active serial: select low during transfers
`timescale 1ns/1ps
`default_nettype none

module ccd_cfg_pins (
	// clock and reset
	input  wire logic                        mclk_i,
	input  wire logic                        rst_n_i,
	// straps and loader core
	input  wire ccd_pkg::ccd_scheme_t        scheme_i,
	input  wire logic                        ap_word_i,
	input  wire logic                        cfg_complete_i,
	// configuration clock pin
	input  wire logic                        config_clock_i,
	output logic                             config_clock_o,
	output logic                             config_clock_oe_n_o,
	// data pins
	input  wire logic [ccd_pkg::DATA_W-1:0]  data_i,
	output logic                             data0_o,
	output logic                             data0_oe_n_o,
	output logic                             serial_memory_command_out_o,
	output logic                             data1_oe_n_o,
	output logic                             serial_memory_select_n_o,
	// user logic control of the pins in user mode
	input  wire logic                        user_clock_own_i,
	input  wire logic                        user_clock_i,
	input  wire logic                        user_clock_oe_n_i,
	input  wire logic [1:0]                  user_data_i,
	input  wire logic [1:0]                  user_data_oe_n_i,
	output logic      [1:0]                  user_data_o,
	// configuration stream
	output logic      [ccd_pkg::DATA_W-1:0]  cfg_data_o,
	output logic                             cfg_data_valid_o,
	output logic                             cfg_word_o,
	output logic                             configuring_o,
	output logic                             user_mode_o
);
	import ccd_pkg::*;

	ccd_state_t          state;
	ccd_scheme_t         scheme_q;
	logic                word_q;
	logic [DIV_W-1:0]    div_cnt;
	logic                clk_q;
	logic [CMD_W-1:0]    cmd_sh;
	logic [5:0]          cmd_cnt;
	logic                cmd_bit_q;
	logic                read_armed;
	logic [BYTE_W-1:0]   bit_sh;
	logic [2:0]          bit_cnt;

	logic                active;
	logic                serial;
	logic                running;
	logic                tick;
	logic                gen_rise;
	logic                gen_fall;
	logic                cap_evt;
	logic                cap_bit;

	logic                next_clk_out;
	logic                next_clk_oe_n;
	logic                next_d0_out;
	logic                next_d0_oe_n;
	logic                next_d1_out;
	logic                next_d1_oe_n;
	logic                next_sel_n;

	ccd_sync_if sif ();

	// pin synchronisers for the link clock and data lines
	ccd_pin_sync u_sync (
		.mclk_i         (mclk_i),
		.rst_n_i        (rst_n_i),
		.config_clock_i (config_clock_i),
		.data_i         (data_i),
		.sync           (sif.src)
	);

	// scheme decode
	assign active  = (scheme_q == active_serial_scheme) ||
	                 (scheme_q == active_parallel_scheme);
	assign serial  = (scheme_q == active_serial_scheme) ||
	                 (scheme_q == passive_serial_scheme);
	assign running = (state == st_config) && active;

	// sequence: idle, configuring, then user mode for good
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			state <= st_idle;
		end else begin
			case (state)
				st_idle: begin
					state <= st_config;
				end
				st_config: begin
					if (cfg_complete_i) begin
						state <= st_user;
					end
				end
				st_user: begin
					state <= st_user;
				end
				default: begin
					state <= st_idle;
				end
			endcase
		end
	end

	// straps caught on the first edge after reset release
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			scheme_q <= passive_serial_scheme;
			word_q   <= 1'b0;
		end else if (state == st_idle) begin
			scheme_q <= scheme_i;
			word_q   <= ap_word_i;
		end
	end

	// divider for the generated configuration clock
	assign tick     = running && (div_cnt == DIV_LAST);
	assign gen_rise = tick && !clk_q;
	assign gen_fall = tick && clk_q;

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i || !running) begin
			div_cnt <= '0;
		end else if (tick) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_cnt + 1'b1;
		end
	end

	// generated clock level, idle level outside configuration
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i || !running) begin
			clk_q <= CLK_IDLE_LEVEL;
		end else if (tick) begin
			clk_q <= ~clk_q;
		end
	end

	// read command shifted out on falling edges, counted on rising edges
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			cmd_sh    <= AS_READ_CMD;
			cmd_cnt   <= '0;
			cmd_bit_q <= 1'b0;
		end else if (state == st_idle) begin
			cmd_sh    <= AS_READ_CMD;
			cmd_cnt   <= '0;
		end else if (scheme_q == active_serial_scheme && cmd_cnt != CMD_BITS) begin
			if (gen_fall) begin
				cmd_bit_q <= cmd_sh[CMD_W-1];
				cmd_sh    <= {cmd_sh[CMD_W-2:0], 1'b0};
			end
			if (gen_rise) begin
				cmd_cnt <= cmd_cnt + 1'b1;
			end
		end
	end

	// read data valid from the first rising edge after the command
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i || !running) begin
			read_armed <= 1'b0;
		end else if (gen_rise) begin
			if (scheme_q == active_parallel_scheme || cmd_cnt == CMD_BITS) begin
				read_armed <= 1'b1;
			end
		end
	end

	// capture: host edge in passive schemes, falling edge after ours in active
	// ones, so the four-flop delay still sees the bit set up at our rise
	always_comb begin
		cap_evt = 1'b0;
		if (state == st_config) begin
			if (!active) begin
				cap_evt = sif.clk_rise;
			end else begin
				cap_evt = gen_fall && read_armed;
			end
		end
	end

	assign cap_bit = sif.data[0];

	// serial bits gathered msb first into bytes
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i || state != st_config) begin
			bit_sh  <= '0;
			bit_cnt <= '0;
		end else if (cap_evt && serial) begin
			bit_sh  <= {bit_sh[BYTE_W-2:0], cap_bit};
			bit_cnt <= bit_cnt + 1'b1;
		end
	end

	// stream output, one pulse per byte or word
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			cfg_data_o       <= '0;
			cfg_data_valid_o <= 1'b0;
			cfg_word_o       <= 1'b0;
		end else begin
			cfg_data_valid_o <= 1'b0;
			if (cap_evt) begin
				if (serial) begin
					if (bit_cnt == BIT_LAST) begin
						cfg_data_o       <= {8'h00, bit_sh[BYTE_W-2:0], cap_bit};
						cfg_data_valid_o <= 1'b1;
						cfg_word_o       <= 1'b0;
					end
				end else if (scheme_q == active_parallel_scheme && word_q) begin
					cfg_data_o       <= sif.data;
					cfg_data_valid_o <= 1'b1;
					cfg_word_o       <= 1'b1;
				end else begin
					cfg_data_o       <= {8'h00, sif.data[BYTE_W-1:0]};
					cfg_data_valid_o <= 1'b1;
					cfg_word_o       <= 1'b0;
				end
			end
		end
	end

	// configuration clock pin drive
	always_comb begin
		next_clk_out  = CLK_IDLE_LEVEL;
		next_clk_oe_n = 1'b1;
		if (running) begin
			next_clk_out  = clk_q;
			next_clk_oe_n = 1'b0;
		end else if (state == st_user && active) begin
			if (user_clock_own_i) begin
				next_clk_out  = user_clock_i;
				next_clk_oe_n = user_clock_oe_n_i;
			end else begin
				next_clk_out  = CLK_IDLE_LEVEL;
				next_clk_oe_n = 1'b0;
			end
		end
	end

	// data line zero: input while configuring, then per scheme
	always_comb begin
		next_d0_out  = 1'b0;
		next_d0_oe_n = 1'b1;
		if (state == st_user) begin
			if (scheme_q == active_serial_scheme) begin
				next_d0_oe_n = 1'b1;
			end else begin
				next_d0_out  = user_data_i[0];
				next_d0_oe_n = user_data_oe_n_i[0];
			end
		end
	end

	// data line one: command out while configuring in active serial, tristate in other schemes, then per scheme in user mode
	always_comb begin
		next_d1_out  = 1'b0;
		next_d1_oe_n = 1'b1;
		if (state == st_config) begin
			if (scheme_q == active_serial_scheme) begin
				next_d1_out  = cmd_bit_q;
				next_d1_oe_n = 1'b0;
			end
		end else if (state == st_user) begin
			if (scheme_q == active_serial_scheme) begin
				next_d1_out  = user_data_i[1];
				next_d1_oe_n = 1'b0;
			end else begin
				next_d1_out  = user_data_i[1];
				next_d1_oe_n = user_data_oe_n_i[1];
			end
		end
	end

	// memory select low for the whole active serial transfer
	always_comb begin
		next_sel_n = 1'b1;
		if (running && scheme_q == active_serial_scheme) begin
			next_sel_n = 1'b0;
		end
	end

	// registered pin outputs
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			config_clock_o              <= CLK_IDLE_LEVEL;
			config_clock_oe_n_o         <= 1'b1;
			data0_o                     <= 1'b0;
			data0_oe_n_o                <= 1'b1;
			serial_memory_command_out_o <= 1'b0;
			data1_oe_n_o                <= 1'b1;
			serial_memory_select_n_o    <= 1'b1;
		end else begin
			config_clock_o              <= next_clk_out;
			config_clock_oe_n_o         <= next_clk_oe_n;
			data0_o                     <= next_d0_out;
			data0_oe_n_o                <= next_d0_oe_n;
			serial_memory_command_out_o <= next_d1_out;
			data1_oe_n_o                <= next_d1_oe_n;
			serial_memory_select_n_o    <= next_sel_n;
		end
	end

	// status and user view of the low data lines
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			configuring_o <= 1'b0;
			user_mode_o   <= 1'b0;
			user_data_o   <= 2'h0;
		end else begin
			configuring_o <= (state == st_config);
			user_mode_o   <= (state == st_user);
			user_data_o   <= sif.data[1:0];
		end
	end

endmodule : ccd_cfg_pins

`default_nettype wire

// ===== ccd_cfg_props.sv
/* port assertions for the config clock and data pin block.
   assumes straps stay steady outside reset. */
`timescale 1ns/1ps
`default_nettype none
module ccd_cfg_props (
	// clock and reset
	input wire logic                 mclk_i,
	input wire logic                 rst_n_i,
	// straps and user
	input wire ccd_pkg::ccd_scheme_t scheme_i,
	input wire logic                 user_clock_own_i,
	// pins and stream
	input wire logic                 config_clock_o,
	input wire logic                 config_clock_oe_n_o,
	input wire logic                 data0_oe_n_o,
	input wire logic                 data1_oe_n_o,
	input wire logic                 serial_memory_select_n_o,
	input wire logic [15:0]          cfg_data_o,
	input wire logic                 cfg_data_valid_o,
	input wire logic                 cfg_word_o,
	input wire logic                 configuring_o,
	input wire logic                 user_mode_o
);
	import ccd_pkg::*;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	a_passive_clk_free: assert property (!scheme_i[1] |-> config_clock_oe_n_o)
		else $error("clock pin driven in passive scheme");
	a_active_clk_drv: assert property (scheme_i[1] && configuring_o && $past(configuring_o, 2)
		|-> !config_clock_oe_n_o) else $error("clock pin not driven");
	a_clk_half_per: assert property (scheme_i[1] && configuring_o && $rose(config_clock_o)
		|-> config_clock_o [*4] ##1 (!config_clock_o or (##1 !configuring_o)))
		else $error("clock half period");
	a_clk_idle_user: assert property (scheme_i[1] && user_mode_o && $past(user_mode_o)
		&& !user_clock_own_i && !$past(user_clock_own_i) |-> config_clock_o && !config_clock_oe_n_o)
		else $error("clock not idle in user mode");
	a_sel_low_cfg: assert property (scheme_i == active_serial_scheme && configuring_o
		&& $past(configuring_o, 2) |-> !serial_memory_select_n_o) else $error("select not low");
	a_sel_rel_user: assert property (user_mode_o && $past(user_mode_o) |-> serial_memory_select_n_o)
		else $error("select low in user mode");
	a_as_d0_input: assert property (scheme_i == active_serial_scheme |-> data0_oe_n_o)
		else $error("line zero driven in active serial");
	a_as_d1_drv: assert property (scheme_i == active_serial_scheme && configuring_o
		&& $past(configuring_o, 2) |-> !data1_oe_n_o) else $error("line one not driven");
	a_ps_d1_tri: assert property (scheme_i == passive_serial_scheme && configuring_o
		|-> data1_oe_n_o) else $error("line one driven in passive serial");
	a_valid_single: assert property (cfg_data_valid_o |=> !cfg_data_valid_o)
		else $error("valid longer than one cycle");
	a_no_cap_user: assert property (user_mode_o && $past(user_mode_o, 2) |-> !cfg_data_valid_o)
		else $error("capture in user mode");
	a_fpp_byte_out: assert property (scheme_i == fast_passive_parallel_scheme && cfg_data_valid_o
		|-> !cfg_word_o && cfg_data_o[15:8] == 8'h00) else $error("parallel capture not a byte");
endmodule // ccd_cfg_props
bind ccd_cfg_pins ccd_cfg_props props_u (.mclk_i, .rst_n_i, .scheme_i, .user_clock_own_i,
	.config_clock_o, .config_clock_oe_n_o, .data0_oe_n_o, .data1_oe_n_o,
	.serial_memory_select_n_o, .cfg_data_o, .cfg_data_valid_o, .cfg_word_o,
	.configuring_o, .user_mode_o);
`default_nettype wire

// ===== ccd_far_model.sv
/* far side of the config port: passive host, serial memory or parallel flash.
   assumes the bench calls host_send in passive schemes, and in active ones only in user mode. */
`timescale 1ns/1ps
`default_nettype none
module ccd_far_model (
	// clock and reset
	input wire logic                 mclk_i,
	input wire logic                 rst_n_i,
	// device side
	input wire ccd_pkg::ccd_scheme_t scheme_i,
	input wire logic                 config_clock_o,
	input wire logic                 config_clock_oe_n_o,
	input wire logic                 serial_memory_command_out_o,
	input wire logic                 serial_memory_select_n_o,
	// resolved pins
	output logic                     clk_pin,
	output logic [15:0]              data_pin
);
	import ccd_pkg::*;
	logic        host_clk = 1'b1;
	logic [15:0] host_dq  = 16'h0000;
	logic [15:0] mem_dq   = 16'hFFFF;
	logic [31:0] cmd      = 32'h0000_0000;
	logic [7:0]  b;
	int          rises    = 0;
	int          k        = 0;
	function automatic logic [7:0] pat(input int n);
		return 8'h96 ^ n[7:0];
	endfunction
	// wire levels: device clock when driven, else host level
	assign clk_pin = config_clock_oe_n_o ? host_clk : config_clock_o;
	// deselected serial memory floats line zero, its pull-up then reads high
	assign data_pin = !scheme_i[1] ? host_dq :
		(scheme_i == active_serial_scheme && serial_memory_select_n_o) ? {mem_dq[15:1], 1'b1} :
		mem_dq;
	// restart memory and flash
	always @(posedge mclk_i) if (!rst_n_i) begin
		rises = 0;
		k = 0;
		cmd = 32'h0000_0000;
		mem_dq = {~pat(0), pat(0)};
	end
	// memory takes command bits on clock rise while selected
	always @(posedge clk_pin) if (scheme_i[1] && !config_clock_oe_n_o) begin
		if (!serial_memory_select_n_o && rises < 32)
			cmd = {cmd[30:0], serial_memory_command_out_o};
		rises = rises + 1;
	end
	// new data after each falling clock once the read has started
	always @(negedge clk_pin) if (scheme_i[1] && !config_clock_oe_n_o) begin
		if (scheme_i == active_parallel_scheme && rises > 0) begin
			k = k + 1;
			mem_dq = {~pat(k), pat(k)};
		end else if (scheme_i == active_serial_scheme && rises >= 32) begin
			b = pat((rises - 32) / 8);
			mem_dq = {15'h7FFF, b[7 - (rises - 32) % 8]};
		end
	end
	// host clocks n bits or bytes, 80 ns period, data set at fall
	task automatic host_send(input logic [7:0] v, input logic ser, input int n);
		int i;
		for (i = 0; i < n; i++) begin
			@(posedge mclk_i);
			host_clk <= 1'b0;
			host_dq <= ser ? {15'h0000, v[7 - i]} : {8'h00, v};
			repeat (4) @(posedge mclk_i);
			host_clk <= 1'b1;
			repeat (3) @(posedge mclk_i);
		end
	endtask
endmodule // ccd_far_model
`default_nettype wire

// ===== tb_top.sv
/* self-checking bench for the config clock and data pin block.
   assumes the far model resolves the clock and data pins. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import ccd_pkg::*;
	typedef struct packed {
		ccd_scheme_t sch;
		logic        wd;
		logic        clk_oe_n;
		logic        d0_oe_n;
	} ccd_row_t;
	ccd_row_t    rows [5];
	logic        mclk_i = 1'b0, rst_n_i = 1'b0, ap_word_i = 1'b0, cfg_complete_i = 1'b0;
	ccd_scheme_t scheme_i = passive_serial_scheme;
	logic        user_clock_own_i = 1'b0, user_clock_i = 1'b1, user_clock_oe_n_i = 1'b1;
	logic [1:0]  user_data_i = 2'b00, user_data_oe_n_i = 2'b11, user_data_o;
	logic        clk_pin, config_clock_o, config_clock_oe_n_o, data0_o, data0_oe_n_o;
	logic        cmd_out, data1_oe_n_o, sel_n, cfg_data_valid_o, cfg_word_o;
	logic        configuring_o, user_mode_o;
	logic [15:0] data_pin, cfg_data_o;
	logic [15:0] got [$];
	int          errors = 0, total_checks = 0, i, r, n;
	ccd_cfg_pins dut_u (.mclk_i, .rst_n_i, .scheme_i, .ap_word_i, .cfg_complete_i,
		.config_clock_i(clk_pin), .config_clock_o, .config_clock_oe_n_o, .data_i(data_pin),
		.data0_o, .data0_oe_n_o, .serial_memory_command_out_o(cmd_out), .data1_oe_n_o,
		.serial_memory_select_n_o(sel_n), .user_clock_own_i, .user_clock_i, .user_clock_oe_n_i,
		.user_data_i, .user_data_oe_n_i, .user_data_o, .cfg_data_o, .cfg_data_valid_o,
		.cfg_word_o, .configuring_o, .user_mode_o);
	ccd_far_model far_u (.mclk_i, .rst_n_i, .scheme_i, .config_clock_o, .config_clock_oe_n_o,
		.serial_memory_command_out_o(cmd_out), .serial_memory_select_n_o(sel_n),
		.clk_pin, .data_pin);
	// 100 MHz clock
	initial forever #5 mclk_i = ~mclk_i;
	// collect captured units
	always @(posedge mclk_i) if (cfg_data_valid_o === 1'b1) got.push_back(cfg_data_o);
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic do_reset(input ccd_scheme_t s, input logic w);
		@(posedge mclk_i);
		rst_n_i <= 1'b0;
		cfg_complete_i <= 1'b0;
		user_data_oe_n_i <= 2'b11;
		user_clock_own_i <= 1'b0;
		user_clock_oe_n_i <= 1'b1;
		scheme_i <= s;
		ap_word_i <= w;
		repeat (12) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		got.delete();
		repeat (4) @(posedge mclk_i);
	endtask
	task automatic wait_units(input int cnt);
		int t;
		for (t = 0; t < 4000 && got.size() < cnt; t++) @(posedge mclk_i);
		if (got.size() < cnt) begin
			errors++;
			report_and_stop();
		end
	endtask
	// main sequence: one row per scheme, two for active parallel byte and word, then reset and partial byte
	initial begin
		rows[0] = '{passive_serial_scheme, 1'b0, 1'b1, 1'b0};
		rows[1] = '{fast_passive_parallel_scheme, 1'b0, 1'b1, 1'b0};
		rows[2] = '{active_serial_scheme, 1'b0, 1'b0, 1'b1};
		rows[3] = '{active_parallel_scheme, 1'b0, 1'b0, 1'b0};
		rows[4] = '{active_parallel_scheme, 1'b1, 1'b0, 1'b0};
		for (r = 0; r < 5; r++) begin
			do_reset(rows[r].sch, rows[r].wd);
			if (!rows[r].sch[1]) for (i = 0; i < 3; i++)
				far_u.host_send(8'h96 ^ i[7:0], !rows[r].sch[0], rows[r].sch[0] ? 1 : 8);
			wait_units(3);
			for (i = 0; i < 3; i++)
				chk("cfg_data", got[i], {rows[r].wd ? ~(8'h96 ^ i[7:0]) : 8'h00, 8'h96 ^ i[7:0]});
			chk("cfg_word", cfg_word_o, rows[r].wd);
			if (rows[r].sch == active_serial_scheme) chk("command", far_u.cmd, AS_READ_CMD);
			@(posedge mclk_i);
			cfg_complete_i <= 1'b1;
			user_data_oe_n_i <= 2'b00;
			user_data_i <= 2'b11;
			repeat (4) @(posedge mclk_i);
			chk("user_mode", user_mode_o, 1'b1);
			chk("clk_oe_n", config_clock_oe_n_o, rows[r].clk_oe_n);
			chk("clk_idle", config_clock_o | config_clock_oe_n_o, 1'b1);
			chk("d0_oe_n", data0_oe_n_o, rows[r].d0_oe_n);
			chk("d1_oe_n", data1_oe_n_o, 1'b0);
			chk("d1_out", cmd_out, 1'b1);
			chk("d0_out", data0_o, !rows[r].d0_oe_n);
			user_clock_own_i <= 1'b1;
			user_clock_i <= 1'b0;
			user_clock_oe_n_i <= 1'b0;
			repeat (3) @(posedge mclk_i);
			chk("clk_user", config_clock_o | config_clock_oe_n_o, rows[r].clk_oe_n);
			user_clock_oe_n_i <= 1'b1;
			n = got.size();
			far_u.host_send(8'h5A, 1'b1, 8);
			repeat (8) @(posedge mclk_i);
			chk("user_captures", got.size(), n);
			chk("user_data", user_data_o, data_pin[1:0]);
		end
		// reset values while held
		@(posedge mclk_i);
		rst_n_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		chk("reset", {config_clock_oe_n_o, data0_oe_n_o, data1_oe_n_o, sel_n, config_clock_o,
			configuring_o, user_mode_o, cfg_data_valid_o}, 8'hF8);
		// partial serial byte at completion is dropped
		do_reset(passive_serial_scheme, 1'b0);
		far_u.host_send(8'hC3, 1'b1, 4);
		repeat (8) @(posedge mclk_i);
		cfg_complete_i <= 1'b1;
		repeat (8) @(posedge mclk_i);
		chk("partial", got.size(), 0);
		report_and_stop();
	end
endmodule // tb_top
`default_nettype wire
